// File: pkg/gpio_pkg.sv
// Constants shared by the dual-port GPIO block
// Function
// - A direction bit of one makes its pin an output and zero an input, per pin, on both ports.
// - An output pin is driven push-pull to its latch bit, with its pull-up off.
// - An input pin whose latch bit is one gets its pull-up, unless the global pull-up disable is set.
// - The pull-up is off when the latch bit is zero, the pin is an output, or the global disable is set.
// - While reset is low every pin of both ports floats, without waiting for a clock.
// - Reading a latch register address returns the stored latch, not the pin levels.
// - Reading a pin-level address returns the pin levels; it holds no storage and has no reset value.
// - Pin-level addresses are read-only and ignore writes; latch and direction registers are read-write.
// - Each port is eight bits wide; all eight Port A pins behave alike as plain I/O, as do Port B bits 0 to 5.
// - Pin levels pass through synchronising flip-flops before they can be read.
// - With the SPI enabled as slave, Port B bit 7 is forced to input; as master its direction bit rules.
// - With the SPI enabled as master, Port B bit 6 is forced to input; as slave its direction bit rules.
// - A pin forced to input by the SPI still has its pull-up steered by its latch bit.
`default_nettype none

package gpio_pkg;

   localparam int unsigned PORT_W    = 8;
   localparam int unsigned IO_ADDR_W = 6;

   // I/O space offsets
   localparam logic [5:0] B_PINS_ADDR  = 6'h16;
   localparam logic [5:0] B_DIR_ADDR   = 6'h17;
   localparam logic [5:0] B_LATCH_ADDR = 6'h18;
   localparam logic [5:0] A_PINS_ADDR  = 6'h19;
   localparam logic [5:0] A_DIR_ADDR   = 6'h1A;
   localparam logic [5:0] A_LATCH_ADDR = 6'h1B;

   // Values after reset, and the value read at unmapped addresses
   localparam logic [7:0] DIR_RESET   = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] PINS_OFF    = 8'h00;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;

   // Port B pins taken over by the SPI
   localparam int unsigned CLOCK_PIN_BIT     = 7;
   localparam int unsigned MASTER_IN_PIN_BIT = 6;

   // Input synchroniser depth and cycles until its output is meaningful
   localparam int unsigned SYNC_STAGES = 2;
   localparam logic [1:0]  WARM_CYCLES = 2'h3;

endpackage

`default_nettype wire

// File: verilog/gpio_input_sync.sv
// Two-stage synchroniser for the pin levels of both ports
`default_nettype none

module gpio_input_sync
   import gpio_pkg::*;
#(
   parameter int unsigned WIDTH = 2 * PORT_W
)
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_b,
   // Raw pins in, synchronised levels out
   input  wire logic [WIDTH-1:0] pinIn,
   output var  logic [WIDTH-1:0] pinSync
);

   typedef struct packed {
      logic [WIDTH-1:0] stage2;
      logic [WIDTH-1:0] stage1;
   } sync_state_s;

   sync_state_s state_reg;
   sync_state_s state_next;

   // First stage feeds only the second
   always_comb begin
      state_next.stage1 = pinIn;
      state_next.stage2 = state_reg.stage1;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pinSync = state_reg.stage2;

endmodule

`default_nettype wire

// File: verilog/gpio_pin_drive.sv
// Per-pin drive and pull-up decode for one 8-bit port
`default_nettype none

module gpio_pin_drive
   import gpio_pkg::*;
(
   // Port configuration
   input  wire logic [PORT_W-1:0] direction,
   input  wire logic [PORT_W-1:0] latch,
   input  wire logic [PORT_W-1:0] forceInput,
   input  wire logic              pullupDisable,
   // Pin controls
   output logic      [PORT_W-1:0] pinOut,
   output logic      [PORT_W-1:0] pinOe,
   output logic      [PORT_W-1:0] pullupEn
);

   genvar i;

   // Every pin is decoded by the same slice
   generate
      for (i = 0; i < PORT_W; i = i + 1) begin : g_pin
         logic drives;
         assign drives      = direction[i] & ~forceInput[i];
         assign pinOe[i]    = drives;
         // Output data held low while floating keeps the pad quiet
         assign pinOut[i]   = drives & latch[i];
         assign pullupEn[i] = ~drives & latch[i] & ~pullupDisable;
      end
   endgenerate

endmodule

`default_nettype wire

// File: verilog/gpio_dual_port.sv
// Dual-port GPIO: registers, pin drive, pin sampling and SPI direction overrides
`default_nettype none

module gpio_dual_port
   import gpio_pkg::*;
(
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst_b,
   // Processor I/O space access
   input  wire logic [IO_ADDR_W-1:0] ioAddr,
   input  wire logic                 ioWrEn,
   input  wire logic                 ioRdEn,
   input  wire logic [PORT_W-1:0]    ioWrData,
   output var  logic [PORT_W-1:0]    ioRdData,
   // Controls from elsewhere in the chip
   input  wire logic                 globalPullupDisable,
   input  wire logic                 spiEnable,
   input  wire logic                 spiMaster,
   // Port A pins
   input  wire logic [PORT_W-1:0]    aPinIn,
   output var  logic [PORT_W-1:0]    aPinOut,
   output var  logic [PORT_W-1:0]    aPinOe,
   output var  logic [PORT_W-1:0]    aPullupEn,
   // Port B pins
   input  wire logic [PORT_W-1:0]    bPinIn,
   output var  logic [PORT_W-1:0]    bPinOut,
   output var  logic [PORT_W-1:0]    bPinOe,
   output var  logic [PORT_W-1:0]    bPullupEn
);

   typedef struct packed {
      logic [PORT_W-1:0] aDir;
      logic [PORT_W-1:0] aLatch;
      logic [PORT_W-1:0] bDir;
      logic [PORT_W-1:0] bLatch;
      logic [PORT_W-1:0] rdData;
      logic [PORT_W-1:0] aOe;
      logic [PORT_W-1:0] aOut;
      logic [PORT_W-1:0] aPu;
      logic [PORT_W-1:0] bOe;
      logic [PORT_W-1:0] bOut;
      logic [PORT_W-1:0] bPu;
   } gpio_state_s;

   gpio_state_s         state_reg;
   gpio_state_s         state_next;
   logic [2*PORT_W-1:0] pinSync;
   logic [PORT_W-1:0]   bForceIn;
   logic [PORT_W-1:0]   aOeComb;
   logic [PORT_W-1:0]   aOutComb;
   logic [PORT_W-1:0]   aPuComb;
   logic [PORT_W-1:0]   bOeComb;
   logic [PORT_W-1:0]   bOutComb;
   logic [PORT_W-1:0]   bPuComb;

   // SPI takes the clock pin as slave and the master-in pin as master
   always_comb begin
      bForceIn                    = '0;
      bForceIn[CLOCK_PIN_BIT]     = spiEnable & ~spiMaster;
      bForceIn[MASTER_IN_PIN_BIT] = spiEnable & spiMaster;
   end

   gpio_input_sync u_inputSync (
      .clock   (clock),
      .rst_b   (rst_b),
      .pinIn   ({bPinIn, aPinIn}),
      .pinSync (pinSync)
   );

   gpio_pin_drive u_aDrive (
      .direction     (state_reg.aDir),
      .latch         (state_reg.aLatch),
      .forceInput    ('0),
      .pullupDisable (globalPullupDisable),
      .pinOut        (aOutComb),
      .pinOe         (aOeComb),
      .pullupEn      (aPuComb)
   );

   gpio_pin_drive u_bDrive (
      .direction     (state_reg.bDir),
      .latch         (state_reg.bLatch),
      .forceInput    (bForceIn),
      .pullupDisable (globalPullupDisable),
      .pinOut        (bOutComb),
      .pinOe         (bOeComb),
      .pullupEn      (bPuComb)
   );

   always_comb begin
      state_next = state_reg;
      // Pin-level addresses fall to the default and are dropped
      if (ioWrEn) begin
         case (ioAddr)
            A_DIR_ADDR:   state_next.aDir   = ioWrData;
            A_LATCH_ADDR: state_next.aLatch = ioWrData;
            B_DIR_ADDR:   state_next.bDir   = ioWrData;
            B_LATCH_ADDR: state_next.bLatch = ioWrData;
            default: begin
            end
         endcase
      end
      // Read data holds between reads; a read beside a write sees the old value
      if (ioRdEn) begin
         case (ioAddr)
            A_PINS_ADDR:  state_next.rdData = pinSync[PORT_W-1:0];
            A_DIR_ADDR:   state_next.rdData = state_reg.aDir;
            A_LATCH_ADDR: state_next.rdData = state_reg.aLatch;
            B_PINS_ADDR:  state_next.rdData = pinSync[2*PORT_W-1:PORT_W];
            B_DIR_ADDR:   state_next.rdData = state_reg.bDir;
            B_LATCH_ADDR: state_next.rdData = state_reg.bLatch;
            default:      state_next.rdData = UNMAPPED_RD;
         endcase
      end
      // Pins follow the registers one cycle later, from flops
      state_next.aOe  = aOeComb;
      state_next.aOut = aOutComb;
      state_next.aPu  = aPuComb;
      state_next.bOe  = bOeComb;
      state_next.bOut = bOutComb;
      state_next.bPu  = bPuComb;
   end

   // Drive enables clear at once under reset, clock or no clock
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '{aDir: DIR_RESET, aLatch: LATCH_RESET,
                        bDir: DIR_RESET, bLatch: LATCH_RESET,
                        default: PINS_OFF};
      end else begin
         state_reg <= state_next;
      end
   end

   assign ioRdData  = state_reg.rdData;
   assign aPinOut   = state_reg.aOut;
   assign aPinOe    = state_reg.aOe;
   assign aPullupEn = state_reg.aPu;
   assign bPinOut   = state_reg.bOut;
   assign bPinOe    = state_reg.bOe;
   assign bPullupEn = state_reg.bPu;

   // Checks

   logic [1:0] warmCnt;

   // Pin history before the release means nothing to the synchroniser
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         warmCnt <= 2'h0;
      end else if (warmCnt != WARM_CYCLES) begin
         warmCnt <= warmCnt + 2'h1;
      end
   end

   default clocking cb @(posedge clock);
   endclocking

   default disable iff (!rst_b);

   property p_dir_to_oe;
      (ioWrEn && ioAddr == A_DIR_ADDR) ##1 !(ioWrEn && ioAddr == A_DIR_ADDR)
         |-> ##1 aPinOe == $past(ioWrData, 2);
   endproperty
   a_dir_to_oe: assert property (p_dir_to_oe)
      else $error("port A enables do not follow the written direction");

   property p_out_follows_latch;
      aPinOut == ($past(state_reg.aLatch) & aPinOe)
         && bPinOut == ($past(state_reg.bLatch) & bPinOe)
         && (aPinOe & aPullupEn) == PINS_OFF
         && (bPinOe & bPullupEn) == PINS_OFF;
   endproperty
   a_out_follows_latch: assert property (p_out_follows_latch)
      else $error("driven pin level or pull-up wrong on an output");

   property p_pullup_on;
      (ioWrEn && ioAddr == A_LATCH_ADDR && state_reg.aDir == DIR_RESET)
         ##1 (!ioWrEn && !globalPullupDisable)
         |-> ##1 aPullupEn == $past(ioWrData, 2);
   endproperty
   a_pullup_on: assert property (p_pullup_on)
      else $error("pull-ups do not follow the latch on input pins");

   property p_pullup_disabled;
      globalPullupDisable [*2] |-> aPullupEn == PINS_OFF && bPullupEn == PINS_OFF;
   endproperty
   a_pullup_disabled: assert property (p_pullup_disabled)
      else $error("pull-up on while globally disabled");

   property p_pullup_latch_zero;
      ##1 (aPullupEn & ~$past(state_reg.aLatch)) == PINS_OFF
         && (bPullupEn & ~$past(state_reg.bLatch)) == PINS_OFF;
   endproperty
   a_pullup_latch_zero: assert property (p_pullup_latch_zero)
      else $error("pull-up on with latch bit zero");

   property p_reset_float;
      @(posedge clock) disable iff (1'b0)
      !rst_b |-> aPinOe == PINS_OFF && bPinOe == PINS_OFF
         && aPullupEn == PINS_OFF && bPullupEn == PINS_OFF;
   endproperty
   a_reset_float: assert property (p_reset_float)
      else $error("a pin is driven or pulled during reset");

   property p_reset_regs;
      @(posedge clock) disable iff (1'b0)
      !rst_b |-> state_reg.aDir == DIR_RESET && state_reg.bDir == DIR_RESET
         && state_reg.aLatch == LATCH_RESET && state_reg.bLatch == LATCH_RESET;
   endproperty
   a_reset_regs: assert property (p_reset_regs)
      else $error("registers not cleared by reset");

   property p_latch_read;
      ioRdEn && ioAddr == B_LATCH_ADDR |=> ioRdData == $past(state_reg.bLatch);
   endproperty
   a_latch_read: assert property (p_latch_read)
      else $error("latch read returns something other than the latch");

   property p_latch_read_a;
      ioRdEn && ioAddr == A_LATCH_ADDR |=> ioRdData == $past(state_reg.aLatch);
   endproperty
   a_latch_read_a: assert property (p_latch_read_a)
      else $error("port A latch read returns something other than the latch");

   property p_dir_read;
      (ioWrEn && ioAddr == B_DIR_ADDR) ##1 (ioRdEn && ioAddr == B_DIR_ADDR && !ioWrEn)
         |=> ioRdData == $past(ioWrData, 2);
   endproperty
   a_dir_read: assert property (p_dir_read)
      else $error("direction register does not read back what was written");

   property p_pins_read;
      ioRdEn && ioAddr == A_PINS_ADDR && warmCnt == WARM_CYCLES
         |=> ioRdData == $past(aPinIn, 3);
   endproperty
   a_pins_read: assert property (p_pins_read)
      else $error("port A pin read is not the level two cycles back");

   property p_pins_read_b;
      ioRdEn && ioAddr == B_PINS_ADDR && warmCnt == WARM_CYCLES
         && bPinIn == $past(bPinIn) && bPinIn == $past(bPinIn, 2)
         |=> ioRdData == $past(bPinIn);
   endproperty
   a_pins_read_b: assert property (p_pins_read_b)
      else $error("port B pin read does not show a steady pin level");

   property p_pins_no_write;
      ioWrEn && (ioAddr == A_PINS_ADDR || ioAddr == B_PINS_ADDR)
         |=> $stable(state_reg.aDir) && $stable(state_reg.aLatch)
            && $stable(state_reg.bDir) && $stable(state_reg.bLatch);
   endproperty
   a_pins_no_write: assert property (p_pins_no_write)
      else $error("write to a pin-level address changed a register");

   property p_spi_slave_clock;
      spiEnable && !spiMaster |=> !bPinOe[CLOCK_PIN_BIT];
   endproperty
   a_spi_slave_clock: assert property (p_spi_slave_clock)
      else $error("clock pin driven while the SPI is slave");

   property p_spi_master_clock;
      spiEnable && spiMaster |=> bPinOe[CLOCK_PIN_BIT] == $past(state_reg.bDir[CLOCK_PIN_BIT]);
   endproperty
   a_spi_master_clock: assert property (p_spi_master_clock)
      else $error("clock pin ignores its direction bit as master");

   property p_spi_master_in;
      spiEnable && spiMaster |=> !bPinOe[MASTER_IN_PIN_BIT];
   endproperty
   a_spi_master_in: assert property (p_spi_master_in)
      else $error("master-in pin driven while the SPI is master");

   property p_spi_slave_master_in;
      spiEnable && !spiMaster
         |=> bPinOe[MASTER_IN_PIN_BIT] == $past(state_reg.bDir[MASTER_IN_PIN_BIT]);
   endproperty
   a_spi_slave_master_in: assert property (p_spi_slave_master_in)
      else $error("master-in pin ignores its direction bit as slave");

   property p_forced_pullup;
      spiEnable && !spiMaster && !globalPullupDisable
         |=> bPullupEn[CLOCK_PIN_BIT] == $past(state_reg.bLatch[CLOCK_PIN_BIT]);
   endproperty
   a_forced_pullup: assert property (p_forced_pullup)
      else $error("forced input pin lost its latch-steered pull-up");

   property p_same_slices;
      ##1 (aPinOe == $past(state_reg.aDir)) && (aPullupEn == ($past(state_reg.aLatch)
         & ~$past(state_reg.aDir) & {PORT_W{!$past(globalPullupDisable)}}));
   endproperty
   a_same_slices: assert property (p_same_slices)
      else $error("port A pins do not all decode alike");

   // Main scenarios worth seeing at least once
   c_dir_write: cover property (ioWrEn && ioAddr == A_DIR_ADDR ##2 aPinOe != PINS_OFF);
   c_spi_master: cover property (spiEnable && spiMaster && state_reg.bDir[MASTER_IN_PIN_BIT]);
   c_spi_slave: cover property (spiEnable && !spiMaster && state_reg.bDir[CLOCK_PIN_BIT]);
   c_pin_read: cover property (ioRdEn && ioAddr == B_PINS_ADDR ##1 ioRdData != PINS_OFF);
   c_pullup: cover property (aPullupEn != PINS_OFF);

endmodule

`default_nettype wire

// File: dv/gpio_board_model.sv
// Board-side model of the pads of one 8-bit port
`default_nettype none

module gpio_board_model
(
   // Clock
   input  wire logic       clock,
   // Device pad controls
   input  wire logic [7:0] pinOut,
   input  wire logic [7:0] pinOe,
   input  wire logic [7:0] pullupEn,
   // External drivers on the board
   input  wire logic [7:0] extData,
   input  wire logic [7:0] extEn,
   // Resolved pad level
   output wire logic [7:0] pinLevel
);
   timeunit 1ns;
   timeprecision 1ps;

   // An undriven pad with no pull-up wanders, so never hand back a stable value
   logic [7:0] floatPattern = 8'h55;

   always @(posedge clock) begin
      floatPattern <= ~floatPattern;
   end

   // Device drive wins over the board; then board drive, then pull-up
   assign pinLevel = (pinOe & pinOut) | (~pinOe & extEn & extData)
                   | (~pinOe & ~extEn & pullupEn) | (~pinOe & ~extEn & ~pullupEn & floatPattern);
endmodule

`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the dual-port GPIO block
`default_nettype none

module testbench
   import gpio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic             clock = 1'b0;
   logic             rst_b;
   logic [5:0]       ioAddr;
   logic             ioWrEn;
   logic             ioRdEn;
   logic [7:0]       ioWrData;
   logic [7:0]       ioRdData;
   logic             globalPullupDisable;
   logic             spiEnable;
   logic             spiMaster;
   logic [7:0]       aPinIn, aPinOut, aPinOe, aPullupEn, aExt, aExtEn;
   logic [7:0]       bPinIn, bPinOut, bPinOe, bPullupEn, bExt, bExtEn;
   int               miscompares;
   int               samplesChecked;
   logic [5:0]       rwAddr [4];

   gpio_dual_port i_dut (
      .clock(clock), .rst_b(rst_b), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn),
      .ioWrData(ioWrData), .ioRdData(ioRdData), .globalPullupDisable(globalPullupDisable),
      .spiEnable(spiEnable), .spiMaster(spiMaster),
      .aPinIn(aPinIn), .aPinOut(aPinOut), .aPinOe(aPinOe), .aPullupEn(aPullupEn),
      .bPinIn(bPinIn), .bPinOut(bPinOut), .bPinOe(bPinOe), .bPullupEn(bPullupEn));

   gpio_board_model i_board_a (.clock(clock), .pinOut(aPinOut), .pinOe(aPinOe), .pullupEn(aPullupEn),
      .extData(aExt), .extEn(aExtEn), .pinLevel(aPinIn));
   gpio_board_model i_board_b (.clock(clock), .pinOut(bPinOut), .pinOe(bPinOe), .pullupEn(bPullupEn),
      .extData(bExt), .extEn(bExtEn), .pinLevel(bPinIn));

   always #12.5 clock = ~clock;

   task automatic finish_test();
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      samplesChecked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      ioAddr   <= a;
      ioWrData <= d;
      ioWrEn   <= 1'b1;
      @(posedge clock);
      ioWrEn   <= 1'b0;
   endtask

   task automatic rd_check(input string what, input logic [5:0] a, input logic [7:0] exp);
      @(posedge clock);
      ioAddr <= a;
      ioRdEn <= 1'b1;
      @(posedge clock);
      ioRdEn <= 1'b0;
      #1;
      check(what, exp, ioRdData);
   endtask

   // Expected pad state worked out per bit from direction, latch and SPI overrides
   task automatic port_case(input logic isB, input logic [7:0] dir, input logic [7:0] latch,
                            input logic [7:0] en, input logic [7:0] ext, input logic global_pullup_disable,
                            input logic se, input logic sm);
      logic [7:0] frc;
      logic [7:0] drv;
      logic [7:0] pu;
      logic [7:0] lvl;
      frc = (isB && se) ? (sm ? (8'h01 << MASTER_IN_PIN_BIT) : (8'h01 << CLOCK_PIN_BIT)) : 8'h00;
      drv = dir & ~frc;
      pu  = ~drv & latch & {8{~global_pullup_disable}};
      lvl = (drv & latch) | (~drv & en & ext) | (~drv & ~en & pu);
      @(posedge clock);
      globalPullupDisable <= global_pullup_disable;
      spiEnable           <= se;
      spiMaster           <= sm;
      if (isB) begin
         bExt   <= ext;
         bExtEn <= en;
      end else begin
         aExt   <= ext;
         aExtEn <= en;
      end
      wr(isB ? B_DIR_ADDR : A_DIR_ADDR, dir);
      wr(isB ? B_LATCH_ADDR : A_LATCH_ADDR, latch);
      repeat (4) @(posedge clock);
      #1;
      check("pin enable", drv, isB ? bPinOe : aPinOe);
      check("pin value", drv & latch, isB ? bPinOut : aPinOut);
      check("pullup", pu, isB ? bPullupEn : aPullupEn);
      rd_check("pin levels", isB ? B_PINS_ADDR : A_PINS_ADDR, lvl);
      rd_check("latch", isB ? B_LATCH_ADDR : A_LATCH_ADDR, latch);
      rd_check("direction", isB ? B_DIR_ADDR : A_DIR_ADDR, dir);
   endtask

   initial begin
      repeat (3000) @(posedge clock);
      miscompares++;
      finish_test();
   end

   initial begin
      rst_b = 1'b0;
      ioAddr = 6'h00;
      ioWrEn = 1'b0;
      ioRdEn = 1'b0;
      ioWrData = 8'h00;
      globalPullupDisable = 1'b0;
      spiEnable = 1'b0;
      spiMaster = 1'b0;
      aExt = 8'h00;
      aExtEn = 8'hFF;
      bExt = 8'h00;
      bExtEn = 8'hFF;
      miscompares = 0;
      samplesChecked = 0;
      rwAddr = '{A_DIR_ADDR, A_LATCH_ADDR, B_DIR_ADDR, B_LATCH_ADDR};
      repeat (2) @(posedge clock);
      #1;
      check("reset enable a", 8'h00, aPinOe | aPullupEn);
      check("reset enable b", 8'h00, bPinOe | bPullupEn);
      @(posedge clock);
      rst_b <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd_check("reset value", rwAddr[i], 8'h00);
      end
      // Writes to pin-level and unmapped places must land nowhere
      wr(A_PINS_ADDR, 8'hFF);
      wr(B_PINS_ADDR, 8'hFF);
      wr(6'h3F, 8'hFF);
      repeat (3) @(posedge clock);
      rd_check("a pins after write", A_PINS_ADDR, 8'h00);
      rd_check("b pins after write", B_PINS_ADDR, 8'h00);
      rd_check("unmapped", 6'h3F, UNMAPPED_RD);
      for (int i = 0; i < 4; i++) begin
         rd_check("untouched", rwAddr[i], 8'h00);
      end
      // Write then read of the same register on consecutive edges
      @(posedge clock);
      ioAddr   <= B_DIR_ADDR;
      ioWrData <= 8'h96;
      ioWrEn   <= 1'b1;
      @(posedge clock);
      ioWrEn   <= 1'b0;
      ioRdEn   <= 1'b1;
      @(posedge clock);
      ioRdEn   <= 1'b0;
      #1;
      check("back to back", 8'h96, ioRdData);
      // Pin change visible only after two synchroniser stages
      @(posedge clock);
      aExt   <= 8'hFF;
      ioAddr <= A_PINS_ADDR;
      ioRdEn <= 1'b1;
      @(posedge clock);
      #1;
      check("sync first", 8'h00, ioRdData);
      @(posedge clock);
      #1;
      check("sync second", 8'h00, ioRdData);
      @(posedge clock);
      ioRdEn <= 1'b0;
      #1;
      check("sync third", 8'hFF, ioRdData);
      port_case(1'b0, 8'hF0, 8'hA5, 8'hFF, 8'h3C, 1'b0, 1'b0, 1'b0);
      port_case(1'b0, 8'h00, 8'hFF, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      port_case(1'b0, 8'h0F, 8'hFF, 8'hFF, 8'h55, 1'b1, 1'b0, 1'b0);
      port_case(1'b1, 8'h3C, 8'hC3, 8'hFF, 8'h5A, 1'b0, 1'b0, 1'b0);
      // SPI pins left with their direction bits set to output, so only the SPI override can make them inputs
      port_case(1'b1, 8'hFF, 8'hFF, 8'hFF, 8'h00, 1'b0, 1'b1, 1'b0);
      port_case(1'b1, 8'hFF, 8'h00, 8'hFF, 8'hFF, 1'b0, 1'b1, 1'b1);
      port_case(1'b1, 8'hFF, 8'hFF, 8'hFF, 8'h00, 1'b0, 1'b0, 1'b1);
      // Second reset in mid-run: pads must float before any clock edge
      @(posedge clock);
      rst_b <= 1'b0;
      #1;
      check("midrun enable b", 8'h00, bPinOe | bPullupEn);
      check("midrun enable a", 8'h00, aPinOe | aPullupEn);
      @(posedge clock);
      rst_b <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd_check("reset again", rwAddr[i], 8'h00);
      end
      finish_test();
   end
endmodule

`default_nettype wire
